/* dv/bridge_primary_command_register_tb_top.sv */
// Purpose: Self-checking bench of the primary command register
// Assumes: Host model drives config, bench drives the gate inputs
// Notes:   Seeded random writes and gate traffic with corner cases
`timescale 1ns/10ps
`default_nettype none
`include "bridge_cmd_cfg.svh"
module bridge_primary_command_register_tb_top;
    logic                      clk, rst, cfg_strobe, cfg_write, cfg_ack;
    logic [5:0]                cfg_dword, dw;
    logic [3:0]                cfg_be_n, be;
    logic [31:0]               cfg_wdata, cfg_rdata, p_addr, wd, rd;
    logic                      p_valid, p_io_in_win, p_mem_in_win, p_claim, p_vga_fwd;
    logic                      s_valid, s_fwd_range, s_claim, m_req, m_mwi_fwd, m_b2b_want;
    logic                      m_go, m_fbb, data_perr, addr_perr, primary_master, serr_event;
    logic                      p_perr_o, p_perr_oe, p_serr_o, p_serr_oe, dpr_set;
    logic [15:0]               cmd_value, cmd_exp;
    bridge_cmd_pkg::txn_kind_t p_kind, s_kind, m_kind;
    int                        miscompares, cmp_count;
    bridge_primary_command_register dut (.clk(clk), .rst(rst), .cfg_strobe(cfg_strobe),
        .cfg_write(cfg_write), .cfg_dword(cfg_dword), .cfg_be_n(cfg_be_n),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .p_valid(p_valid),
        .p_kind(p_kind), .p_addr(p_addr), .p_io_in_win(p_io_in_win),
        .p_mem_in_win(p_mem_in_win), .p_claim(p_claim), .p_vga_fwd(p_vga_fwd),
        .s_valid(s_valid), .s_kind(s_kind), .s_fwd_range(s_fwd_range), .s_claim(s_claim),
        .m_req(m_req), .m_kind(m_kind), .m_mwi_fwd(m_mwi_fwd), .m_b2b_want(m_b2b_want),
        .m_go(m_go), .m_fbb(m_fbb), .data_perr(data_perr), .addr_perr(addr_perr),
        .primary_master(primary_master), .serr_event(serr_event), .p_perr_o(p_perr_o),
        .p_perr_oe(p_perr_oe), .p_serr_o(p_serr_o), .p_serr_oe(p_serr_oe),
        .dpr_set(dpr_set), .cmd_value(cmd_value));
    cfg_host u_host (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .cfg_strobe(cfg_strobe), .cfg_write(cfg_write), .cfg_dword(cfg_dword),
        .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata));
    // ********************************
    // Checking and expectations
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [7:0] exp_gates(input logic [15:0] c);
        logic pio, pmem, hit, scl, go;
        pio = p_kind <= bridge_cmd_pkg::txn_io_write;
        pmem = p_kind inside {[bridge_cmd_pkg::txn_mem_read:bridge_cmd_pkg::txn_mem_wr_inv]};
        hit = p_kind == bridge_cmd_pkg::txn_io_write && p_addr[31:16] == 16'h0000
            && (p_addr[9:0] inside {`VGA_PAL_MASK_ADDR, `VGA_PAL_WR_ADDR, `VGA_PAL_DATA_ADDR});
        scl = s_valid && s_fwd_range && (s_kind <= bridge_cmd_pkg::txn_mem_wr_inv ? c[2]
            : s_kind == bridge_cmd_pkg::txn_config);
        go = m_req && (m_kind == bridge_cmd_pkg::txn_mem_wr_inv ? c[2] && m_mwi_fwd
            : (m_kind == bridge_cmd_pkg::txn_config
               || (m_kind < bridge_cmd_pkg::txn_mem_wr_inv && c[2])));
        return {p_valid && ((pio && c[0] && p_io_in_win) || (hit && c[5])
            || (pmem && c[1] && p_mem_in_win)), p_valid && hit && c[5], scl, go,
            go && m_b2b_want && c[9], c[6] && data_perr, c[6] && data_perr && primary_master,
            c[8] && ((c[6] && addr_perr) || serr_event)};
    endfunction
    task automatic gate_round;
        logic [9:0] pal [5];
        pal = '{10'h3c6, 10'h3c8, 10'h3c9, 10'h3c7, 10'h1c8};
        @(posedge clk);
        #1;
        {p_valid, p_io_in_win, p_mem_in_win, s_valid, s_fwd_range, m_req} = 6'($urandom);
        {m_mwi_fwd, m_b2b_want, data_perr, addr_perr, primary_master, serr_event} = 6'($urandom);
        p_kind = bridge_cmd_pkg::txn_kind_t'($urandom_range(0, 6));
        s_kind = bridge_cmd_pkg::txn_kind_t'($urandom_range(0, 6));
        m_kind = bridge_cmd_pkg::txn_kind_t'($urandom_range(0, 6));
        if (p_kind == bridge_cmd_pkg::txn_config) begin
            p_kind = bridge_cmd_pkg::txn_io_write;
        end
        p_addr = {($urandom_range(0, 3) == 0) ? 16'($urandom) : 16'h0000, 6'($urandom),
            pal[$urandom_range(0, 4)]};
        #2;
        check({p_claim, p_vga_fwd, s_claim, m_go, m_fbb, p_perr_oe, dpr_set, p_serr_oe},
            exp_gates(cmd_exp), "gates");
        check({p_perr_o, p_serr_o}, 32'h0000_0000, "pin values");
    endtask
    // ********************************
    // Sequence
    // ********************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        {p_valid, p_io_in_win, p_mem_in_win, s_valid, s_fwd_range, m_req} = 6'h00;
        {m_mwi_fwd, m_b2b_want, data_perr, addr_perr, primary_master, serr_event} = 6'h00;
        p_kind = bridge_cmd_pkg::txn_io_read;
        s_kind = bridge_cmd_pkg::txn_io_read;
        m_kind = bridge_cmd_pkg::txn_io_read;
        p_addr = 32'h0000_0000;
        miscompares = 0;
        cmp_count = 0;
        cmd_exp = 16'h0000;
        void'($urandom(60843));
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        u_host.xfer(1'b0, `CMD_DWORD, 4'h0, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000, "reset read");
        gate_round();
        // Software sets the register up before relying on it
        u_host.xfer(1'b1, `CMD_DWORD, 4'h0, 32'hffff_ffff, rd);
        check(rd, 32'h0000_0000, "all ones return");
        cmd_exp = `CMD_WRITE_MASK;
        check(cmd_value, cmd_exp, "all ones");
        for (int i = 0; i < 60; i++) begin
            dw = 6'($urandom_range(0, 2));
            be = 4'($urandom);
            wd = $urandom;
            u_host.xfer(1'b1, dw, be, wd, rd);
            if (dw == `CMD_DWORD && !be[0]) begin
                cmd_exp[7:0] = wd[7:0] & 8'(`CMD_WRITE_MASK);
            end
            if (dw == `CMD_DWORD && !be[1]) begin
                cmd_exp[15:8] = wd[15:8] & 8'h03;
            end
            check(rd, 32'h0000_0000, "write return");
            check(cmd_value, cmd_exp, "after write");
            u_host.xfer(1'b0, dw, 4'h0, 32'h0000_0000, rd);
            check(rd, (dw == `CMD_DWORD) ? {16'h0000, cmd_exp} : 32'h0000_0000, "read");
            repeat (4) gate_round();
        end
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        cmd_exp = 16'h0000;
        check(cmd_value, cmd_exp, "second reset");
        repeat (8) gate_round();
        stop_test();
    end
endmodule
bind bridge_primary_command_register cmd_monitor u_mon (.clk(clk), .rst(rst),
    .cfg_strobe(cfg_strobe), .cfg_ack(cfg_ack), .cmd_value(cmd_value), .p_valid(p_valid),
    .p_kind(p_kind), .p_addr(p_addr), .p_claim(p_claim), .p_vga_fwd(p_vga_fwd),
    .s_kind(s_kind), .s_claim(s_claim), .m_kind(m_kind), .m_go(m_go),
    .m_b2b_want(m_b2b_want), .m_fbb(m_fbb), .data_perr(data_perr), .addr_perr(addr_perr),
    .serr_event(serr_event), .p_perr_oe(p_perr_oe), .p_serr_oe(p_serr_oe));
`default_nettype wire

/* dv/cfg_host.sv */
// Purpose: Configuration master on the primary bus
// Assumes: Caller enters one step after a rising edge
// Notes:   Lines are scrambled once the data phase is taken
`timescale 1ns/10ps
`default_nettype none
module cfg_host (
    input  wire logic        clk,        // Primary clock
    input  wire logic        cfg_ack,    // Access done
    input  wire logic [31:0] cfg_rdata,  // Read data
    output logic             cfg_strobe, // Data phase
    output logic             cfg_write,  // Write select
    output logic [5:0]       cfg_dword,  // Dword offset
    output logic [3:0]       cfg_be_n,   // Byte enables
    output logic [31:0]      cfg_wdata   // Write data
);
    initial begin
        cfg_strobe = 1'b0;
        cfg_write = 1'b0;
        cfg_dword = 6'h00;
        cfg_be_n = 4'hf;
        cfg_wdata = 32'h0000_0000;
    end
    // One Type 0 data phase, dword and low-active enables
    task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        cfg_strobe = 1'b1;
        cfg_write = wr;
        cfg_dword = dw;
        cfg_be_n = be;
        cfg_wdata = wd;
        @(posedge clk);
        #1;
        cfg_strobe = 1'b0;
        cfg_dword = ~dw;
        cfg_wdata = ~wd;
        n = 0;
        while (cfg_ack !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        // Answer is read while it stands; a lost ack returns unknowns
        rd = (cfg_ack === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* dv/cmd_monitor.sv */
// Purpose: Assertions on the ports of the primary command register
// Assumes: Bound to the top module, one clock domain
// Notes:   Combinational gates are sampled on the rising edge
`timescale 1ns/10ps
`default_nettype none
module cmd_monitor (
    input wire logic                      clk,        // Primary clock
    input wire logic                      rst,        // Async reset
    input wire logic                      cfg_strobe, // Config phase
    input wire logic                      cfg_ack,    // Access done
    input wire logic [15:0]               cmd_value,  // Register
    input wire logic                      p_valid,    // Primary txn
    input wire bridge_cmd_pkg::txn_kind_t p_kind,     // Primary kind
    input wire logic [31:0]               p_addr,     // Primary addr
    input wire logic                      p_claim,    // Primary claim
    input wire logic                      p_vga_fwd,  // Palette claim
    input wire bridge_cmd_pkg::txn_kind_t s_kind,     // Secondary kind
    input wire logic                      s_claim,    // Secondary claim
    input wire bridge_cmd_pkg::txn_kind_t m_kind,     // Issue kind
    input wire logic                      m_go,       // Issue allowed
    input wire logic                      m_b2b_want, // Back to back
    input wire logic                      m_fbb,      // Fast b2b
    input wire logic                      data_perr,  // Data parity
    input wire logic                      addr_perr,  // Addr parity
    input wire logic                      serr_event, // Error cause
    input wire logic                      p_perr_oe,  // Parity drive
    input wire logic                      p_serr_oe   // Serr drive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ********************************
    // Checks
    // ********************************
    ack_follows_strobe_a: assert property (cfg_ack == $past(cfg_strobe))
        else $error("ack not one cycle after strobe");
    ro_bits_zero_a: assert property ((cmd_value & 16'hfc98) == 16'h0000)
        else $error("read-only bit set");
    io_claim_gate_a: assert property (
        p_valid && p_kind == bridge_cmd_pkg::txn_io_read && !cmd_value[0] |-> !p_claim)
        else $error("io read claimed while disabled");
    mem_claim_gate_a: assert property (p_claim |->
        p_kind != bridge_cmd_pkg::txn_special && (p_kind < bridge_cmd_pkg::txn_mem_read || cmd_value[1]))
        else $error("memory or special claimed");
    sec_master_gate_a: assert property (
        s_claim && s_kind != bridge_cmd_pkg::txn_config |-> cmd_value[2])
        else $error("secondary claim without master enable");
    init_master_gate_a: assert property (
        m_go && m_kind != bridge_cmd_pkg::txn_config |-> cmd_value[2])
        else $error("initiation without master enable");
    vga_needs_snoop_a: assert property (
        p_vga_fwd |-> cmd_value[5] && p_claim && p_addr[31:16] == 16'h0000)
        else $error("palette claim without snoop");
    perr_gate_a: assert property (p_perr_oe == (cmd_value[6] && data_perr))
        else $error("parity pin drive wrong");
    serr_gate_a: assert property (
        p_serr_oe |-> cmd_value[8] && ((cmd_value[6] && addr_perr) || serr_event))
        else $error("system error pin driven while disabled");
    fbb_gate_a: assert property (m_fbb |-> cmd_value[9] && m_b2b_want && m_go)
        else $error("fast back to back without enable");
    cover property (p_vga_fwd);
    cover property (p_serr_oe);
    cover property (m_fbb);
endmodule
`default_nettype wire

/* rtl/bridge_cmd_cfg.svh */
// Purpose: Constants for the primary command register of the bridge
// Assumes: Included by bare name from the design files
// Notes:   Offsets, width, bit positions, masks, reset values and palette addresses only
`ifndef BRIDGE_CMD_CFG_SVH
`define BRIDGE_CMD_CFG_SVH

// ****************************************************************
// Register placement
// ****************************************************************
`define CMD_DWORD          6'h01
`define CMD_WIDTH          16
`define CMD_RESET          16'h0000
`define CMD_WRITE_MASK     16'h0367

// ****************************************************************
// Field positions
// ****************************************************************
`define CMD_IO_EN          0
`define CMD_MEM_EN         1
`define CMD_MASTER_EN      2
`define CMD_SPECIAL_EN     3
`define CMD_MWI_EN         4
`define CMD_VGA_SNOOP      5
`define CMD_PERR_RESP      6
`define CMD_WAIT_CTL       7
`define CMD_SERR_EN        8
`define CMD_FBB_EN         9

// ****************************************************************
// Palette decode
// ****************************************************************
`define VGA_PAL_MASK_ADDR  10'h3c6
`define VGA_PAL_WR_ADDR    10'h3c8
`define VGA_PAL_DATA_ADDR  10'h3c9

`endif

/* rtl/bridge_cmd_pkg.sv */
// Purpose: Types shared by the bridge command register design
// Assumes: Nothing beyond the configuration header
// Notes:   Used by scope, never imported
package bridge_cmd_pkg;

    // Bus command class of a transaction seen by the bridge
    typedef enum logic [2:0] {
        txn_io_read,
        txn_io_write,
        txn_mem_read,
        txn_mem_write,
        txn_mem_wr_inv,
        txn_config,
        txn_special
    } txn_kind_t;

    // Whole state of the register block
    typedef struct packed {
        logic [15:0] cmd;
        logic [31:0] rdata;
        logic        ack;
    } cmd_state_t;

endpackage

/* rtl/bridge_primary_command_register.sv */
// Purpose: Primary command register of a bus-to-bus bridge and the
//          enables it applies to the primary and secondary interfaces
// Assumes: Type 0 configuration cycles are decoded outside; this block
//          sees one strobe per data phase with dword offset and byte
//          enables (active low)
// Notes:   Status half of the dword reads zero here
//
// Overview of operation
// - I/O space enable clear blocks claiming primary I/O except snooped palette writes; resets zero.
// - Memory space enable clear blocks claiming primary memory; resets zero.
// - Master enable gates secondary claims and primary initiation; resets zero.
// - Configuration forwarding ignores the master enable.
// - Special cycles ignored; special cycle enable reads zero.
// - Invalidate enable reads zero; invalidate issued only when forwarding one.
// - Palette write: I/O write, bits 9:0 match, 31:16 zero.
// - Snoop enable claims palette writes; else only inside I/O window.
// - Parity response clear suppresses parity pin, status set and address errors.
// - Parity response set allows parity pin, status set and address errors.
// - Wait cycle control bit reads zero.
// - System error enable clear never drives system error pin; resets zero.
// - Fast back-to-back generation only while its enable is set.
// - Bits 15:10 are reserved and read zero.
`timescale 1ns/10ps
`default_nettype none
`include "bridge_cmd_cfg.svh"

module bridge_primary_command_register (
    input  wire logic                      clk,            // Primary bus clock
    input  wire logic                      rst,            // Asynchronous reset
    // Configuration access
    input  wire logic                      cfg_strobe,     // Data phase of Type 0 cycle
    input  wire logic                      cfg_write,      // 1 write, 0 read
    input  wire logic [5:0]                cfg_dword,      // Dword offset
    input  wire logic [3:0]                cfg_be_n,       // Byte enables, low active
    input  wire logic [31:0]               cfg_wdata,      // Write data
    output logic [31:0]                    cfg_rdata,      // Read data
    output logic                           cfg_ack,        // Access done
    // Primary target side
    input  wire logic                      p_valid,        // Primary transaction
    input  wire bridge_cmd_pkg::txn_kind_t p_kind,         // Its command class
    input  wire logic [31:0]               p_addr,         // Its address
    input  wire logic                      p_io_in_win,    // Inside I/O window
    input  wire logic                      p_mem_in_win,   // Inside memory window
    output logic                           p_claim,        // Bridge claims it
    output logic                           p_vga_fwd,      // Claimed as palette write
    // Secondary target side
    input  wire logic                      s_valid,        // Secondary transaction
    input  wire bridge_cmd_pkg::txn_kind_t s_kind,         // Its command class
    input  wire logic                      s_fwd_range,    // Address goes upstream
    output logic                           s_claim,        // Bridge claims it
    // Primary initiator side
    input  wire logic                      m_req,          // Queue wants primary
    input  wire bridge_cmd_pkg::txn_kind_t m_kind,         // Command to issue
    input  wire logic                      m_mwi_fwd,      // Carries forwarded MWI
    input  wire logic                      m_b2b_want,     // Next cycle back to back
    output logic                           m_go,           // Initiation allowed
    output logic                           m_fbb,          // Fast back-to-back allowed
    // Error signalling
    input  wire logic                      data_perr,      // Data parity error
    input  wire logic                      addr_perr,      // Address parity error
    input  wire logic                      primary_master, // Master on primary
    input  wire logic                      serr_event,     // Other system error cause
    output logic                           p_perr_o,       // Parity pin value
    output logic                           p_perr_oe,      // Parity pin drive
    output logic                           p_serr_o,       // System error pin value
    output logic                           p_serr_oe,      // System error pin drive
    output logic                           dpr_set,        // Data parity reported set
    // Enables for the rest of the bridge
    output logic [15:0]                    cmd_value       // Current register
);

    bridge_cmd_pkg::cmd_state_t state;
    bridge_cmd_pkg::cmd_state_t next_state;

    logic vga_hit;
    logic io_en;
    logic mem_en;
    logic master_en;
    logic vga_snoop;
    logic perr_resp;
    logic serr_en;
    logic fbb_en;
    logic hit_cmd;

    // ****************************************************************
    // Byte merge with low-active enable
    // ****************************************************************
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                               input logic [7:0] new_v,
                                               input logic       be_n,
                                               input logic [7:0] wmask);
        logic [7:0] sel;
        sel = be_n ? 8'h00 : wmask;
        merge_byte = (old_v & ~sel) | (new_v & sel);
    endfunction

    // ****************************************************************
    // Enable fields
    // ****************************************************************
    always_comb begin
        io_en     = state.cmd[`CMD_IO_EN];
        mem_en    = state.cmd[`CMD_MEM_EN];
        master_en = state.cmd[`CMD_MASTER_EN];
        vga_snoop = state.cmd[`CMD_VGA_SNOOP];
        perr_resp = state.cmd[`CMD_PERR_RESP];
        serr_en   = state.cmd[`CMD_SERR_EN];
        fbb_en    = state.cmd[`CMD_FBB_EN];
    end

    // ****************************************************************
    // Configuration access
    // ****************************************************************
    always_comb begin
        next_state = state;
        hit_cmd    = cfg_strobe && (cfg_dword == `CMD_DWORD);
        next_state.ack = cfg_strobe;
        if (cfg_strobe && cfg_write) begin
            next_state.rdata = 32'h0000_0000;
        end
        if (hit_cmd && cfg_write) begin
            // Read-only bits keep zero because the mask never selects them
            next_state.cmd[7:0]  = merge_byte(state.cmd[7:0], cfg_wdata[7:0],
                                              cfg_be_n[0],
                                              8'(`CMD_WRITE_MASK));
            next_state.cmd[15:8] = merge_byte(state.cmd[15:8], cfg_wdata[15:8],
                                              cfg_be_n[1],
                                              8'(`CMD_WRITE_MASK >> 8));
        end
        if (cfg_strobe && !cfg_write) begin
            if (hit_cmd) begin
                // Reserved and fixed bits are forced to zero on the way out
                next_state.rdata = {16'h0000,
                                    state.cmd & `CMD_WRITE_MASK};
            end else begin
                next_state.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state.cmd   <= `CMD_RESET;
            state.rdata <= 32'h0000_0000;
            state.ack   <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign cfg_rdata = state.rdata;
    assign cfg_ack   = state.ack;
    assign cmd_value = state.cmd;

    // ****************************************************************
    // Palette decode
    // ****************************************************************
    vga_palette_decode u_vga (
        .valid (p_valid),
        .kind  (p_kind),
        .addr  (p_addr),
        .hit   (vga_hit)
    );

    // ****************************************************************
    // Primary target claim
    // ****************************************************************
    always_comb begin
        p_vga_fwd = vga_hit && vga_snoop;
        p_claim   = 1'b0;
        if (p_valid) begin
            case (p_kind)
                bridge_cmd_pkg::txn_io_read:  p_claim = io_en && p_io_in_win;
                bridge_cmd_pkg::txn_io_write: p_claim = p_vga_fwd ||
                                                        (io_en && p_io_in_win);
                bridge_cmd_pkg::txn_mem_read,
                bridge_cmd_pkg::txn_mem_write,
                bridge_cmd_pkg::txn_mem_wr_inv: p_claim = mem_en && p_mem_in_win;
                bridge_cmd_pkg::txn_special:  p_claim = 1'b0;
                default:                      p_claim = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Secondary target claim
    // ****************************************************************
    always_comb begin
        s_claim = 1'b0;
        if (s_valid && s_fwd_range) begin
            case (s_kind)
                bridge_cmd_pkg::txn_io_read,
                bridge_cmd_pkg::txn_io_write,
                bridge_cmd_pkg::txn_mem_read,
                bridge_cmd_pkg::txn_mem_write,
                bridge_cmd_pkg::txn_mem_wr_inv: s_claim = master_en;
                bridge_cmd_pkg::txn_config:   s_claim = 1'b1;
                bridge_cmd_pkg::txn_special:  s_claim = 1'b0;
                default:                      s_claim = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Primary initiation
    // ****************************************************************
    always_comb begin
        m_go = 1'b0;
        if (m_req) begin
            case (m_kind)
                bridge_cmd_pkg::txn_io_read,
                bridge_cmd_pkg::txn_io_write,
                bridge_cmd_pkg::txn_mem_read,
                bridge_cmd_pkg::txn_mem_write: m_go = master_en;
                bridge_cmd_pkg::txn_mem_wr_inv: m_go = master_en && m_mwi_fwd;
                bridge_cmd_pkg::txn_config:   m_go = 1'b1;
                default:                      m_go = 1'b0;
            endcase
        end
        m_fbb = m_go && m_b2b_want && fbb_en;
    end

    // ****************************************************************
    // Error pins
    // ****************************************************************
    parity_serr_gate u_err (
        .perr_resp      (perr_resp),
        .serr_en        (serr_en),
        .data_perr      (data_perr),
        .addr_perr      (addr_perr),
        .primary_master (primary_master),
        .serr_event     (serr_event),
        .perr_oe        (p_perr_oe),
        .dpr_set        (dpr_set),
        .serr_oe        (p_serr_oe)
    );

    // Open-drain style pins only ever pull low
    assign p_perr_o = 1'b0;
    assign p_serr_o = 1'b0;

endmodule
`default_nettype wire

/* rtl/parity_serr_gate.sv */
// Purpose: Gate primary parity and system error signalling
// Assumes: Detection events come from the primary bus logic
// Notes:   Error pins are open drain: only the enable toggles
`timescale 1ns/10ps
`default_nettype none

module parity_serr_gate (
    input  wire logic perr_resp,      // Parity error response enable
    input  wire logic serr_en,        // System error enable
    input  wire logic data_perr,      // Data parity error detected
    input  wire logic addr_perr,      // Address parity error detected
    input  wire logic primary_master, // Bridge is master on primary
    input  wire logic serr_event,     // Other system error condition
    output logic      perr_oe,        // Drive primary parity error pin
    output logic      dpr_set,        // Set data-parity-reported status
    output logic      serr_oe         // Drive primary system error pin
);

    // ****************************************************************
    // Gating
    // ****************************************************************
    always_comb begin
        perr_oe = perr_resp && data_perr;
        dpr_set = perr_resp && data_perr && primary_master;
        serr_oe = serr_en && ((perr_resp && addr_perr) || serr_event);
    end

endmodule
`default_nettype wire

/* rtl/vga_palette_decode.sv */
// Purpose: Recognise a palette write on the primary bus
// Assumes: Address and command are stable while valid is high
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "bridge_cmd_cfg.svh"

module vga_palette_decode (
    input  wire logic                  valid,    // Transaction present
    input  wire bridge_cmd_pkg::txn_kind_t kind, // Bus command class
    input  wire logic [31:0]           addr,     // Primary address
    output logic                       hit       // Palette write seen
);

    logic low_match;

    // ****************************************************************
    // Decode: bits 9:0 compared, 15:10 ignored, 31:16 zero
    // ****************************************************************
    always_comb begin
        low_match = (addr[9:0] == `VGA_PAL_MASK_ADDR) ||
                    (addr[9:0] == `VGA_PAL_WR_ADDR)   ||
                    (addr[9:0] == `VGA_PAL_DATA_ADDR);
        hit = valid && (kind == bridge_cmd_pkg::txn_io_write) && low_match &&
              (addr[31:16] == 16'h0000);
    end

endmodule
`default_nettype wire
